// ---- design/wake_src_map.vh ----
// Functional notes
// - mode 000 low, 001 high, 010 falling, 011 rising, 100 either edge
// - edge status 01 rising, 10 falling, 11 both, 00 nothing recorded
// - edge status meaningful only while mode is either-edge
// - software reads edge status to learn which edge woke the device
// - clearing a request through the clear register also clears edge status
// - mode at 6-4/14-12/22-20/30-28, enable at bits 0/8/16/24
// - edge status at 3-2/11-10/19-18/27-26, read-only
`ifndef WAKE_SRC_MAP_VH
`define WAKE_SRC_MAP_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define MODE_CTRL_B_OFS 4'h0
`define REQ_CLEAR_OFS 4'h4
`define REQ_STATUS_OFS 4'h8

// ----------------------------------------
// field layout per source, byte lane i
// ----------------------------------------
`define SRC_STRIDE 8
`define EN_POS 0
`define ST_POS 2
`define MODE_POS 4

// ----------------------------------------
// mode codes, reset value and edge status codes
// ----------------------------------------
`define MODE_LOW 3'h0
`define MODE_HIGH 3'h1
`define MODE_FALL 3'h2
`define MODE_RISE 3'h3
`define MODE_BOTH 3'h4
`define MODE_RST 3'h2
`define ST_RISE 2'h1
`define ST_FALL 2'h2

`endif

// ---- design/wake_source_ctrl.v ----
// Added by the designer: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/100ps
`include "wake_src_map.vh"

module wake_source_ctrl #(
	parameter NSRC = 4
)(
	input wire aclk,
	input wire aresetn,
	input wire [3:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [3:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire [3:0] wake_in,
	output reg [3:0] wake_req
);

// ----------------------------------------
// state
// ----------------------------------------
reg [2:0] mode_q [0:3];
reg [1:0] st_q [0:3];
reg [3:0] en_q;
reg [3:0] in_q;
reg [3:0] pend_q;
reg [3:0] aw_addr_q;
reg aw_have_q;
reg [31:0] w_data_q;
reg [3:0] w_strb_q;
reg w_have_q;
reg [31:0] reg_word;
reg [31:0] rd_word;
reg [3:0] cond;
reg [3:0] rise;
reg [3:0] fall;
reg [3:0] clr;
wire do_write;
integer i, j, k;

assign do_write = aw_have_q & w_have_q & ~s_axi_bvalid;

// ----------------------------------------
// register image
// ----------------------------------------
always @*
begin
	reg_word = 32'h0;
	for (j = 0; j < NSRC; j = j + 1)
	begin
		reg_word[j*`SRC_STRIDE+`MODE_POS +: 3] = mode_q[j];
		reg_word[j*`SRC_STRIDE+`ST_POS +: 2] = st_q[j];
		reg_word[j*`SRC_STRIDE+`EN_POS] = en_q[j];
	end
end

always @*
begin
	case (s_axi_araddr)
		`MODE_CTRL_B_OFS: rd_word = reg_word;
		`REQ_STATUS_OFS: rd_word = {28'h0, pend_q};
		default: rd_word = 32'h0;
	endcase
end

// ----------------------------------------
// detection conditions
// ----------------------------------------
always @*
begin
	rise = 4'h0;
	fall = 4'h0;
	cond = 4'h0;
	clr = 4'h0;
	for (k = 0; k < NSRC; k = k + 1)
	begin
		rise[k] = wake_in[k] & ~in_q[k];
		fall[k] = ~wake_in[k] & in_q[k];
		case (mode_q[k])
			`MODE_LOW: cond[k] = ~wake_in[k];
			`MODE_HIGH: cond[k] = wake_in[k];
			`MODE_FALL: cond[k] = fall[k];
			`MODE_RISE: cond[k] = rise[k];
			`MODE_BOTH: cond[k] = rise[k] | fall[k];
			default: cond[k] = 1'b0;
		endcase
		clr[k] = do_write && aw_addr_q == `REQ_CLEAR_OFS &&
			w_strb_q[k] && w_data_q[k*`SRC_STRIDE];
	end
end

// ----------------------------------------
// wake logic
// ----------------------------------------
always @(posedge aclk)
begin
	if (!aresetn)
	begin
		in_q <= 4'h0;
		pend_q <= 4'h0;
		wake_req <= 4'h0;
		en_q <= 4'h0;
		for (i = 0; i < NSRC; i = i + 1)
		begin
			mode_q[i] <= `MODE_RST;
			st_q[i] <= 2'h0;
		end
	end
	else
	begin
		in_q <= wake_in;
		for (i = 0; i < NSRC; i = i + 1)
		begin
			// enabled wake condition in modes 000 to 100 sets the request (modes 101-111 never do); set wins over clear
			if (en_q[i] && cond[i])
				pend_q[i] <= 1'b1;
			else if (clr[i])
				pend_q[i] <= 1'b0;
			if (en_q[i] && mode_q[i] == `MODE_BOTH && (rise[i] | fall[i]))
				st_q[i] <= st_q[i] | (rise[i] ? `ST_RISE : `ST_FALL);
			else if (clr[i] || mode_q[i] != `MODE_BOTH)
				st_q[i] <= 2'h0;
			wake_req[i] <= en_q[i] & cond[i];
			if (do_write && aw_addr_q == `MODE_CTRL_B_OFS && w_strb_q[i])
			begin
				// mode and enable written together from byte lane i by software
				mode_q[i] <= w_data_q[i*`SRC_STRIDE+`MODE_POS +: 3];
				en_q[i] <= w_data_q[i*`SRC_STRIDE+`EN_POS];
			end
		end
	end
end

// ----------------------------------------
// axi4-lite slave
// ----------------------------------------
always @(posedge aclk)
begin
	if (!aresetn)
	begin
		s_axi_awready <= 1'b1;
		s_axi_wready <= 1'b1;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= 2'h0;
		s_axi_arready <= 1'b1;
		s_axi_rvalid <= 1'b0;
		s_axi_rresp <= 2'h0;
		s_axi_rdata <= 32'h0;
		aw_have_q <= 1'b0;
		w_have_q <= 1'b0;
		aw_addr_q <= 4'h0;
		w_data_q <= 32'h0;
		w_strb_q <= 4'h0;
	end
	else
	begin
		if (s_axi_awvalid && s_axi_awready)
		begin
			aw_addr_q <= s_axi_awaddr;
			aw_have_q <= 1'b1;
			s_axi_awready <= 1'b0;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			w_data_q <= s_axi_wdata;
			w_strb_q <= s_axi_wstrb;
			w_have_q <= 1'b1;
			s_axi_wready <= 1'b0;
		end
		if (do_write)
		begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (aw_addr_q == `MODE_CTRL_B_OFS ||
				aw_addr_q == `REQ_CLEAR_OFS ||
				aw_addr_q == `REQ_STATUS_OFS) ? 2'h0 : 2'h2;
		end
		if (s_axi_bvalid && s_axi_bready)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
		end
		if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= (s_axi_araddr == `MODE_CTRL_B_OFS ||
				s_axi_araddr == `REQ_CLEAR_OFS ||
				s_axi_araddr == `REQ_STATUS_OFS) ? 2'h0 : 2'h2;
		end
		if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
end

endmodule

// ---- testbench/wake_src_checker.sv ----
`timescale 1ns/100ps
module wake_src_checker(
	input wire aclk,
	input wire aresetn,
	input wire s_axi_awready,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [3:0] s_axi_araddr,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire [31:0] s_axi_rdata,
	input wire [3:0] wake_req
);
default clocking @(posedge aclk); endclocking
default disable iff (!aresetn);
reg [3:0] ar_q = 4'h0;
always @(posedge aclk)
	if (s_axi_arvalid && s_axi_arready)
		ar_q <= s_axi_araddr;
property p_rst;
	$rose(aresetn) |-> wake_req == 0 && !s_axi_bvalid && !s_axi_rvalid;
endproperty
a_rst: assert property (p_rst) else $error("reset");
property p_rz;
	s_axi_rvalid |-> (s_axi_rdata & 32'h80808080) == 0;
endproperty
a_rz: assert property (p_rz) else $error("rsvd");
property p_rm;
	s_axi_rvalid |-> s_axi_rdata[6:4] <= 3'h4 && s_axi_rdata[30:28] <= 3'h4;
endproperty
a_rm: assert property (p_rm) else $error("mode");
property p_st;
	s_axi_rvalid && ar_q == 4'h0 && s_axi_rdata[3:2] != 0 |->
		s_axi_rdata[6:4] == 3'h4;
endproperty
a_st: assert property (p_st) else $error("status");
property p_rr;
	s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
endproperty
a_rr: assert property (p_rr) else $error("rlate");
property p_rh;
	s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
endproperty
a_rh: assert property (p_rh) else $error("rhold");
property p_bh;
	s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
endproperty
a_bh: assert property (p_bh) else $error("bhold");
property p_bw;
	$rose(s_axi_bvalid) |-> !s_axi_awready && !s_axi_wready;
endproperty
a_bw: assert property (p_bw) else $error("busy");
cover property (wake_req != 0);
cover property (s_axi_bvalid && s_axi_bready);
cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind wake_source_ctrl wake_src_checker i_wake_src_checker(.*);

// ---- testbench/wake_pins.sv ----
`timescale 1ns/100ps
module wake_pins(
	input wire aclk,
	input wire [3:0] lvl,
	output reg [3:0] pin = 4'h0
);
always @(posedge aclk)
	pin <= lvl;
endmodule

// ---- testbench/test_standby_wake_source_config.sv ----
`timescale 1ns/100ps
`define CHK(a,b) begin checks++; if ((a) !== (b)) begin fail_count++; \
	$display("[FAIL] %0t %h %h", $time, a, b); end end
module test_standby_wake_source_config;
reg aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
reg s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
reg [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hf, lvl = 0;
reg [31:0] s_axi_wdata = 0;
wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
wire [1:0] s_axi_bresp, s_axi_rresp;
wire [31:0] s_axi_rdata;
wire [3:0] wake_in, wake_req;
int checks = 0, fail_count = 0;
reg [3:0] got;
always #25 aclk = ~aclk;
wake_pins i_wake_pins(.aclk(aclk), .lvl(lvl), .pin(wake_in));
wake_source_ctrl i_wake_source_ctrl(.*);
// ----------------------------------------
// bus tasks and scenarios
// ----------------------------------------
task wr(input [3:0] a, input [31:0] d);
	s_axi_awaddr <= a;
	s_axi_wdata <= d;
	s_axi_awvalid <= 1;
	s_axi_wvalid <= 1;
	s_axi_bready <= 1;
	do
	begin
		@(posedge aclk);
		if (s_axi_awready) s_axi_awvalid <= 0;
		if (s_axi_wready) s_axi_wvalid <= 0;
		if (s_axi_bvalid) s_axi_bready <= 0;
		if (s_axi_bvalid) `CHK(s_axi_bresp, (a > 4'h8 || a[1:0] != 0) ? 2'h2 : 2'h0)
	end while (s_axi_awvalid | s_axi_wvalid | s_axi_bready);
	@(posedge aclk);
endtask
task rd(input [3:0] a, input [31:0] e);
	s_axi_araddr <= a;
	s_axi_arvalid <= 1;
	s_axi_rready <= 1;
	do
	begin
		@(posedge aclk);
		if (s_axi_arready) s_axi_arvalid <= 0;
		if (s_axi_rvalid) s_axi_rready <= 0;
		if (s_axi_rvalid) `CHK(s_axi_rdata, e)
		if (s_axi_rvalid) `CHK(s_axi_rresp, (a > 4'h8 || a[1:0] != 0) ? 2'h2 : 2'h0)
	end while (s_axi_arvalid | s_axi_rready);
	@(posedge aclk);
endtask
task t_reset;
	rd(4'h0, 32'h20202020);
	rd(4'hc, 32'h0);
endtask
task t_modes;
	for (int i = 0; i < 5; i++)
	begin
		wr(4'h0, {4{1'b0, i[2:0], 4'he}});
		rd(4'h0, {4{1'b0, i[2:0], 4'h0}});
	end
endtask
task t_both;
	wr(4'h0, 32'h40404040);
	wr(4'h0, 32'h40404041);
	got = 0;
	lvl <= 4'h1;
	repeat (5) @(posedge aclk) got = got | wake_req;
	`CHK(got, 4'h1)
	rd(4'h0, 32'h40404045);
	lvl <= 4'h0;
	repeat (5) @(posedge aclk);
	rd(4'h0, 32'h4040404d);
	rd(4'h8, 32'h1);
	wr(4'h4, 32'h1);
	rd(4'h0, 32'h40404041);
	rd(4'h8, 32'h0);
endtask
task t_level;
	wr(4'h0, 32'h40404010);
	wr(4'h0, 32'h40404011);
	lvl <= 4'hf;
	repeat (4) @(posedge aclk);
	`CHK(wake_req, 4'h1)
	lvl <= 4'h0;
	repeat (4) @(posedge aclk);
	`CHK(wake_req, 4'h0)
endtask
task stop_test;
	$display("checks %0d fail_count %0d", checks, fail_count);
	if (fail_count == 0 && checks > 0)
		$display("No errors found");
	else
		$display("Errors were found");
	$finish;
endtask
initial
begin
	repeat (8) @(posedge aclk);
	aresetn <= 1;
	@(posedge aclk);
	t_reset;
	t_modes;
	t_both;
	t_level;
	stop_test;
end
initial
begin
	#200000;
	fail_count++;
	stop_test;
end
endmodule
